// File: inc/tlsg_regs.svh
// tlsg_regs.svh: ranges, reset values and timing counts of the torque
// limit and stall guard block.
// assumes the includer runs on a 50 MHz control tick.
`ifndef TLSG_REGS_SVH
`define TLSG_REGS_SVH
`define TLSG_LIM_MAX        16'd300
`define TLSG_LIM_RST        16'd200
`define TLSG_CEIL_CT        16'd150
`define TLSG_CEIL_VT        16'd120
`define TLSG_AN_FULL        16'd100
`define TLSG_GAIN_RST       16'd1000
`define TLSG_GAIN_UNIT      32'd1000
`define TLSG_AN_ZERO_UA     16'd4000
`define TLSG_AN_SPAN_UA     16'd16000
`define TLSG_LVL_MIN        16'd30
`define TLSG_LVL_MAX        16'd200
`define TLSG_LVL_RST_VT     16'd120
`define TLSG_LVL_RST_CT     16'd150
`define TLSG_HYST_PCT       16'd2
`define TLSG_SEL_RST        2'd1
`define TLSG_SEL_MAX        2'd2
`define TLSG_DUTY_RST       1'b1
`define TLSG_CLK_HZ         50000000
`define TLSG_STALL_MS       100
`define TLSG_STALL_CYC      ((`TLSG_CLK_HZ / 1000) * `TLSG_STALL_MS)
`endif

// File: inc/tlsg_pkg.sv
// tlsg_pkg.sv: types shared by the torque limit and stall guard block.
// assumes tlsg_regs.svh sits on the include path.
package tlsg_pkg;
    // control method of the inner loop
    typedef enum logic [1:0] {
        TLSG_VF      = 2'h0,
        TLSG_VF_PG   = 2'h1,
        TLSG_OLV     = 2'h2
    } tlsg_method_t;
    // analog input function codes
    typedef enum logic [4:0] {
        TLSG_AF_POS  = 5'h0A,
        TLSG_AF_NEG  = 5'h0B,
        TLSG_AF_REG  = 5'h0C,
        TLSG_AF_BOTH = 5'h0F
    } tlsg_afunc_t;
    // stall supervisor states, gray along idle->count->decel
    typedef enum logic [1:0] {
        TLSG_ST_IDLE  = 2'b00,
        TLSG_ST_COUNT = 2'b01,
        TLSG_ST_DECEL = 2'b11
    } tlsg_state_t;
    // settings write port
    typedef struct packed {
        logic        wrEn;
        logic [3:0]  wrSel;
        logic [15:0] wrData;
    } tlsg_wr_t;
endpackage

// File: rtl/tlsg_torque_guard.sv
// tlsg_torque_guard.sv: open-loop vector torque clamp by quadrant, analog and
// duty ceiling, plus running stall supervision of output current in TLSG_VF mode.
// assumes inputs synchronous to clk_sys; currents and torques in percent.
`include "tlsg_regs.svh"

////////////////////////////////////////////////////////////////////////
module tlsg_torque_guard
    import tlsg_pkg::*;
#(
    parameter int STALL_CYC = `TLSG_STALL_CYC
) (
    input  wire logic               clk_sys,       // control tick
    input  wire logic               rst_b,         // sync reset, low
    input  wire tlsg_wr_t           setWr,         // settings write
    input  wire tlsg_method_t       ctrlMethod,    // control method
    input  wire logic               running,       // drive in operation
    input  wire logic               revDir,        // reverse rotation
    input  wire logic signed [15:0] torqueIn,      // torque estimate, pct
    input  wire logic [15:0]        auxAnalogInput,// terminal, microamps
    input  wire logic [15:0]        outCurrent,    // output current, pct
    output logic signed [15:0]      torqueOut,     // clamped torque
    output logic                    torqueClamp,   // clamp active
    output logic                    speedRegHold,  // suspend speed loop
    output logic                    stallDecel,    // lower frequency
    output logic                    stallDecelTwo, // use decel time two
    output logic                    wrReject,      // write refused
    output logic [15:0]             effLimit       // applied limit, pct
);
    ////////////////////////////////////////////////////////////////////
    // settings storage: index 0..3 torque limits, 4 func, 5 gain,
    // 6 stall select, 7 stall level, 8 duty select
    logic [15:0] lim_r [4];        // fwd mot, rev mot, fwd rgn, rev rgn
    logic [15:0] lim_nxt [4];
    logic [4:0]  analogFunc_r;     // analog_func_select
    logic [4:0]  analogFunc_nxt;
    logic [15:0] analogGain_r;     // analog_gain, 0.1 percent units
    logic [15:0] analogGain_nxt;
    logic [1:0]  stallSel_r;       // run_stall_select
    logic [1:0]  stallSel_nxt;
    logic [15:0] stallLvl_r;       // run_stall_level
    logic [15:0] stallLvl_nxt;
    logic        duty_r;           // 1 variable torque, 0 constant
    logic        duty_nxt;
    logic        lvlSet_r;         // level written since reset
    logic        lvlSet_nxt;
    logic        wrReject_r;
    logic        wrReject_nxt;

    // settings writes; out-of-range limits, stall select and stall level are refused as well
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lim_nxt[i] = lim_r[i];
        end
        analogFunc_nxt = analogFunc_r;
        analogGain_nxt = analogGain_r;
        stallSel_nxt   = stallSel_r;
        stallLvl_nxt   = stallLvl_r;
        duty_nxt       = duty_r;
        lvlSet_nxt     = lvlSet_r;
        wrReject_nxt   = 1'b0;
        if (setWr.wrEn && running) begin
            wrReject_nxt = 1'b1;
        end else if (setWr.wrEn) begin
            unique case (setWr.wrSel)
                4'h0, 4'h1, 4'h2, 4'h3: begin
                    if (setWr.wrData <= `TLSG_LIM_MAX) begin
                        lim_nxt[setWr.wrSel[1:0]] = setWr.wrData;
                    end else begin
                        wrReject_nxt = 1'b1;
                    end
                end
                4'h4: analogFunc_nxt = setWr.wrData[4:0];
                4'h5: analogGain_nxt = setWr.wrData;
                4'h6: begin
                    if (setWr.wrData[1:0] <= `TLSG_SEL_MAX &&
                        setWr.wrData[15:2] == 14'h0000) begin
                        stallSel_nxt = setWr.wrData[1:0];
                    end else begin
                        wrReject_nxt = 1'b1;
                    end
                end
                4'h7: begin
                    if (setWr.wrData >= `TLSG_LVL_MIN &&
                        setWr.wrData <= `TLSG_LVL_MAX) begin
                        stallLvl_nxt = setWr.wrData;
                        lvlSet_nxt   = 1'b1;
                    end else begin
                        wrReject_nxt = 1'b1;
                    end
                end
                4'h8: begin
                    duty_nxt = setWr.wrData[0];
                    // untouched level follows the duty default
                    if (!lvlSet_r) begin
                        stallLvl_nxt = setWr.wrData[0] ?
                            `TLSG_LVL_RST_VT : `TLSG_LVL_RST_CT;
                    end
                end
                default: wrReject_nxt = 1'b1; // unmapped index
            endcase
        end
    end

    // settings registers
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            for (int i = 0; i < 4; i++) begin
                lim_r[i] <= `TLSG_LIM_RST;
            end
            analogFunc_r <= 5'h00;
            analogGain_r <= `TLSG_GAIN_RST;
            stallSel_r   <= `TLSG_SEL_RST;
            stallLvl_r   <= `TLSG_LVL_RST_VT;
            duty_r       <= `TLSG_DUTY_RST;
            lvlSet_r     <= 1'b0;
            wrReject_r   <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                lim_r[i] <= lim_nxt[i];
            end
            analogFunc_r <= analogFunc_nxt;
            analogGain_r <= analogGain_nxt;
            stallSel_r   <= stallSel_nxt;
            stallLvl_r   <= stallLvl_nxt;
            duty_r       <= duty_nxt;
            lvlSet_r     <= lvlSet_nxt;
            wrReject_r   <= wrReject_nxt;
        end
    end
    assign wrReject = wrReject_r;

    ////////////////////////////////////////////////////////////////////
    // torque limit selection
    logic        posTq;       // torque estimate positive
    logic        regen;       // torque opposes rotation
    logic [15:0] parLim;      // quadrant parameter limit
    logic [47:0] anScaled;    // analog limit before clip, no overflow
    logic [15:0] anLim;       // analog limit, pct
    logic        anApplies;   // analog limit active this quadrant
    logic [15:0] ceilLim;     // duty ceiling
    logic [15:0] minLim;
    logic [15:0] absTq;
    logic signed [15:0] tqNxt;
    logic        clampNxt;
    logic signed [15:0] torqueOut_r;
    logic        clamp_r;
    logic [15:0] effLimit_r;

    always_comb begin
        posTq  = !torqueIn[15];
        regen  = posTq == revDir;
        absTq  = posTq ? torqueIn : 16'(-torqueIn);
        // index: bit0 reverse rotation, bit1 regenerating
        parLim = lim_r[{regen, regen ? posTq : !posTq}];
        // current above 4 mA, scaled to 100 pct then by gain
        // 48 bits: span times percent times a large gain passes 32 bits
        anScaled = (auxAnalogInput > `TLSG_AN_ZERO_UA) ?
            48'(auxAnalogInput - `TLSG_AN_ZERO_UA) * 48'(`TLSG_AN_FULL)
            * 48'(analogGain_r) / (48'(`TLSG_AN_SPAN_UA)
            * 48'(`TLSG_GAIN_UNIT)) : 48'h000000000000;
        anLim = (anScaled > 48'(`TLSG_LIM_MAX)) ? `TLSG_LIM_MAX
            : anScaled[15:0];
        // forward analog limit follows torque sign, not quadrant
        unique case (analogFunc_r)
            TLSG_AF_POS:  anApplies = posTq;
            TLSG_AF_NEG:  anApplies = !posTq;
            TLSG_AF_REG:  anApplies = regen;
            TLSG_AF_BOTH: anApplies = 1'b1;
            default:      anApplies = 1'b0;
        endcase
        ceilLim = duty_r ? `TLSG_CEIL_VT : `TLSG_CEIL_CT;
        minLim  = (parLim < ceilLim) ? parLim : ceilLim;
        if (anApplies && anLim < minLim) begin
            minLim = anLim;
        end
        tqNxt    = torqueIn;
        clampNxt = 1'b0;
        if (ctrlMethod == TLSG_OLV && absTq > minLim) begin
            clampNxt = 1'b1;
            tqNxt    = posTq ? minLim : 16'(-minLim);
        end
    end

    // torque output registers
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            torqueOut_r <= 16'sh0000;
            clamp_r     <= 1'b0;
            // duty resets to variable torque, so its ceiling applies
            effLimit_r  <= `TLSG_CEIL_VT;
        end else begin
            torqueOut_r <= tqNxt;
            clamp_r     <= clampNxt;
            effLimit_r  <= minLim;
        end
    end
    assign torqueOut    = torqueOut_r;
    assign torqueClamp  = clamp_r;
    assign speedRegHold = clamp_r;
    assign effLimit     = effLimit_r;

    ////////////////////////////////////////////////////////////////////
    // running stall supervisor; the count lives in flops, not a timer
    tlsg_state_t state_r;
    tlsg_state_t state_nxt;
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic        stallOn;   // supervision armed
    logic        over;      // current above level
    logic        below;     // current at or below level minus 2

    always_comb begin
        stallOn   = ctrlMethod == TLSG_VF && running &&
                    stallSel_r != 2'd0;
        over      = outCurrent > stallLvl_r;
        below     = outCurrent <= stallLvl_r - `TLSG_HYST_PCT;
        state_nxt = state_r;
        cnt_nxt   = 32'h00000000;
        unique case (state_r)
            TLSG_ST_IDLE:
                if (stallOn && over) begin
                    state_nxt = TLSG_ST_COUNT;
                    cnt_nxt   = 32'h00000001;
                end
            TLSG_ST_COUNT: begin
                if (!stallOn || !over) begin
                    state_nxt = TLSG_ST_IDLE;
                end else if (cnt_r >= 32'(STALL_CYC - 1)) begin
                    state_nxt = TLSG_ST_DECEL;
                end else begin
                    cnt_nxt = cnt_r + 32'h00000001;
                end
            end
            TLSG_ST_DECEL:
                if (!stallOn || below) begin
                    state_nxt = TLSG_ST_IDLE;
                end
            default: state_nxt = TLSG_ST_IDLE;
        endcase
    end

    // stall state registers
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_r <= TLSG_ST_IDLE;
            cnt_r   <= 32'h00000000;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end
    assign stallDecel    = state_r == TLSG_ST_DECEL;
    assign stallDecelTwo = stallSel_r == 2'd2;

    ////////////////////////////////////////////////////////////////////
    // checks
    a_clamp_method: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        ctrlMethod != TLSG_OLV |=> !torqueClamp)
        else $error("clamp outside open-loop vector");
    // every stored limit stays inside the settable range
    for (genvar g = 0; g < 4; g++) begin : g_limChk
        a_lim_range: assert property (
            @(posedge clk_sys) disable iff (!rst_b)
            lim_r[g] <= `TLSG_LIM_MAX)
            else $error("torque limit out of range");
    end
    // effLimit was built from the duty setting one tick earlier
    a_ceil_bound: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        effLimit <= ($past(duty_r) ? `TLSG_CEIL_VT : `TLSG_CEIL_CT))
        else $error("limit above duty ceiling");
    // a held speed loop means the torque sits right on the limit
    a_hold_clamp: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (speedRegHold == torqueClamp) &&
        (!speedRegHold || $unsigned(torqueOut) == effLimit ||
        $unsigned(torqueOut) == 16'(-effLimit)))
        else $error("speed loop hold not matching the clamp");
    a_stall_time: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        $rose(stallDecel) |-> $past(cnt_r) == 32'(STALL_CYC - 1) &&
        $past(state_r) == TLSG_ST_COUNT)
        else $error("decel without full overload count");
    a_stall_sel: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        stallSel_r == 2'd0 |=> !stallDecel)
        else $error("stall active while disabled");
    a_recover: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        stallDecel && below |=> !stallDecel)
        else $error("no recovery below hysteresis");
    a_run_write: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        setWr.wrEn && running |=> wrReject && $stable(lim_r[0]))
        else $error("write accepted while running");
    a_sel_range: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        stallSel_r <= `TLSG_SEL_MAX)
        else $error("stall select out of range");
endmodule

// File: verification/tlsg_loop_model.sv
// tlsg_loop_model.sv: inner control loop and analog terminal stand-in.
// assumes the bench sets the wanted torque, current and terminal level.
module tlsg_loop_model
    import tlsg_pkg::*;
(
    input  wire logic               clk_sys,        // control tick
    input  wire logic signed [15:0] torqueCmd,      // wanted torque, pct
    input  wire logic [15:0]        currentCmd,     // wanted current, pct
    input  wire logic [15:0]        analogCmd,      // wanted terminal, uA
    output logic signed [15:0]      torqueIn,       // torque estimate
    output logic [15:0]             outCurrent,     // measured current
    output logic [15:0]             auxAnalogInput  // terminal level
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////////
    // one tick of lag, as a real estimator answers late; outputs are
    // unknown only until the first tick, which falls inside reset
    always @(posedge clk_sys) begin
        torqueIn <= torqueCmd;
        outCurrent <= currentCmd;
        auxAnalogInput <= analogCmd;
    end
endmodule

// File: verification/test_torque_limit_and_stall_guard.sv
// test_torque_limit_and_stall_guard.sv: self-checking bench of the guard.
// assumes a short stall count so the overload timer ends quickly.
module test_torque_limit_and_stall_guard
    import tlsg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STALL = 10;           // shortened overload count
    logic               clk_sys, rst_b;  // tick and reset
    logic               running, revDir; // run state, rotation
    tlsg_wr_t           setWr;           // settings write
    tlsg_method_t       ctrlMethod;      // control method
    logic signed [15:0] torqueCmd, torqueIn, torqueOut;
    logic [15:0]        currentCmd, analogCmd, outCurrent;
    logic [15:0]        auxAnalogInput, effLimit;
    logic               torqueClamp, speedRegHold, stallDecel;
    logic               stallDecelTwo, wrReject;
    int                 n_mismatch, cmp_count;
    int                 i;

    tlsg_torque_guard #(.STALL_CYC(STALL)) DUT (.clk_sys(clk_sys),
        .rst_b(rst_b), .setWr(setWr), .ctrlMethod(ctrlMethod),
        .running(running), .revDir(revDir), .torqueIn(torqueIn),
        .auxAnalogInput(auxAnalogInput), .outCurrent(outCurrent),
        .torqueOut(torqueOut), .torqueClamp(torqueClamp),
        .speedRegHold(speedRegHold), .stallDecel(stallDecel),
        .stallDecelTwo(stallDecelTwo), .wrReject(wrReject),
        .effLimit(effLimit));
    tlsg_loop_model loop (.clk_sys(clk_sys), .torqueCmd(torqueCmd),
        .currentCmd(currentCmd), .analogCmd(analogCmd),
        .torqueIn(torqueIn), .outCurrent(outCurrent),
        .auxAnalogInput(auxAnalogInput));

    ////////////////////////////////////////////////////////////////////
    // 50 MHz tick
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // compare with case equality so unknowns never pass
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected t=%0t seen %h wanted %h", $time, seen, exp);
        end
    endtask
    // one settings write, then look at the refusal pulse
    task automatic wr(input logic [3:0] sel, input logic [15:0] d,
                      input logic rej);
        @(posedge clk_sys);
        setWr <= '{wrEn: 1'b1, wrSel: sel, wrData: d};
        @(posedge clk_sys);
        setWr.wrEn <= 1'b0;
        #1 check({15'h0000, wrReject}, {15'h0000, rej});
    endtask
    // let model lag and output register land
    task automatic settle;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
    // apply a torque and direction, compare the clamped torque
    task automatic tq(input logic signed [15:0] t, input logic rd,
                      input logic [15:0] exp);
        @(posedge clk_sys);
        torqueCmd <= t;
        revDir <= rd;
        settle();
        check(torqueOut, exp);
    endtask
    // run with a given current; bounded wait for the decel flag
    task automatic stallRun(input logic [15:0] cur);
        @(posedge clk_sys);
        running <= 1'b1;
        currentCmd <= cur;
        for (i = 0; i < 40; i++) begin
            @(posedge clk_sys);
            #1;
            if (stallDecel === 1'b1) break;
        end
        check({15'h0000, stallDecel}, 16'h0001);
        if (i == 40) print_verdict();
    endtask
    // set current (and run state) then settle
    task automatic cur(input logic [15:0] c, input logic run);
        @(posedge clk_sys);
        currentCmd <= c;
        running <= run;
        settle();
    endtask
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        n_mismatch = 0;
        cmp_count = 0;
        rst_b = 1'b0;
        running = 1'b0;
        revDir = 1'b0;
        setWr = '0;
        ctrlMethod = TLSG_VF;
        torqueCmd = 16'h0000;
        currentCmd = 16'h0000;
        analogCmd = 16'h0000;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1 check(effLimit, 16'h0078);
        // default level 120 under variable torque duty
        stallRun(16'h0079);
        cur(16'h0076, 1'b1);
        check({15'h0000, stallDecel}, 16'h0000);
        cur(16'h0000, 1'b0);
        // no clamp outside open-loop vector
        tq(16'h00FA, 1'b0, 16'h00FA);
        check({15'h0000, torqueClamp}, 16'h0000);
        @(posedge clk_sys) ctrlMethod <= TLSG_OLV;
        tq(16'h00FA, 1'b0, 16'h0078);
        check(effLimit, 16'h0078);
        check({15'h0000, speedRegHold}, 16'h0001);
        tq(16'hFF06, 1'b0, 16'hFF88);
        wr(4'h8, 16'h0000, 1'b0);
        tq(16'h00FA, 1'b0, 16'h0096);
        // range refusals and boundaries
        wr(4'h0, 16'h012D, 1'b1);
        wr(4'h0, 16'h012C, 1'b0);
        wr(4'h6, 16'h0003, 1'b1);
        wr(4'h7, 16'h001D, 1'b1);
        wr(4'h7, 16'h00C9, 1'b1);
        wr(4'h7, 16'h001E, 1'b0);
        wr(4'h9, 16'h0000, 1'b1);
        // analog terminal: full scale, below live zero, gain
        wr(4'h4, 16'h000F, 1'b0);
        analogCmd <= 16'h4E20;
        tq(16'h00FA, 1'b0, 16'h0064);
        analogCmd <= 16'h0BB8;
        tq(16'h00FA, 1'b0, 16'h0000);
        analogCmd <= 16'h4E20;
        wr(4'h5, 16'h04B0, 1'b0);
        tq(16'h00FA, 1'b0, 16'h0078);
        wr(4'h5, 16'h03E8, 1'b0);
        analogCmd <= 16'h1F40;
        tq(16'hFF06, 1'b0, 16'hFFE7);
        wr(4'h4, 16'h000A, 1'b0);
        tq(16'h00FA, 1'b1, 16'h0019);
        tq(16'hFF06, 1'b0, 16'hFF6A);
        wr(4'h4, 16'h000B, 1'b0);
        tq(16'hFF06, 1'b1, 16'hFFE7);
        tq(16'h00FA, 1'b0, 16'h0096);
        wr(4'h4, 16'h000C, 1'b0);
        tq(16'hFF06, 1'b0, 16'hFFE7);
        tq(16'h00FA, 1'b0, 16'h0096);
        wr(4'h4, 16'h0000, 1'b0);
        // one limit per quadrant
        wr(4'h0, 16'h0032, 1'b0);
        wr(4'h1, 16'h003C, 1'b0);
        wr(4'h2, 16'h0046, 1'b0);
        wr(4'h3, 16'h0050, 1'b0);
        tq(16'h00FA, 1'b0, 16'h0032);
        tq(16'hFF06, 1'b1, 16'hFFC4);
        tq(16'hFF06, 1'b0, 16'hFFBA);
        tq(16'h00FA, 1'b1, 16'h0050);
        // overload timing with level 100
        @(posedge clk_sys) ctrlMethod <= TLSG_VF;
        wr(4'h7, 16'h0064, 1'b0);
        @(posedge clk_sys);
        running <= 1'b1;
        currentCmd <= 16'h0065;
        repeat (STALL) @(posedge clk_sys);
        #1 check({15'h0000, stallDecel}, 16'h0000);
        stallRun(16'h0065);
        check({15'h0000, stallDecelTwo}, 16'h0000);
        cur(16'h0063, 1'b1);
        check({15'h0000, stallDecel}, 16'h0001);
        cur(16'h0062, 1'b1);
        check({15'h0000, stallDecel}, 16'h0000);
        wr(4'h0, 16'h000A, 1'b1);
        cur(16'h0000, 1'b0);
        wr(4'h6, 16'h0002, 1'b0);
        stallRun(16'h0065);
        check({15'h0000, stallDecelTwo}, 16'h0001);
        cur(16'h0000, 1'b0);
        wr(4'h6, 16'h0000, 1'b0);
        cur(16'h00FA, 1'b1);
        repeat (3 * STALL) @(posedge clk_sys);
        #1 check({15'h0000, stallDecel}, 16'h0000);
        cur(16'h0000, 1'b0);
        wr(4'h6, 16'h0001, 1'b0);
        @(posedge clk_sys) ctrlMethod <= TLSG_OLV;
        cur(16'h00FA, 1'b1);
        repeat (3 * STALL) @(posedge clk_sys);
        #1 check({15'h0000, stallDecel}, 16'h0000);
        print_verdict();
    end
endmodule
